// ---- pkg/dtp_pkg.sv ----
// Package: register map, field layout, modes and timing for the dual 8-bit timer
package dtp_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [4:0] DTP_OFS_CTRL0 = 5'h00;
  localparam logic [4:0] DTP_OFS_CTRL1 = 5'h04;
  localparam logic [4:0] DTP_OFS_CMP0 = 5'h08;
  localparam logic [4:0] DTP_OFS_CMP1 = 5'h0C;
  localparam logic [4:0] DTP_OFS_COUNT = 5'h10;
  localparam logic [4:0] DTP_OFS_IRQ_STS = 5'h14;
  localparam logic [4:0] DTP_OFS_IRQ_MASK = 5'h18;
  localparam logic [4:0] DTP_OFS_MISC = 5'h1C;

  // ==========================================================
  // Control and misc register fields
  localparam int DTP_CTRL_MODE_LSB = 0;
  localparam int DTP_CTRL_START_BIT = 3;
  localparam int DTP_CTRL_CKSEL_LSB = 4;
  localparam int DTP_CTRL_FF_BIT = 7;
  localparam int DTP_MODE_W = 3;
  localparam int DTP_MODE_CASCADE_BIT = 2;
  localparam int DTP_MISC_PSSEL_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] DTP_RST_CTRL = 8'h00;
  localparam logic [7:0] DTP_RST_CMP = 8'h00;
  localparam logic [1:0] DTP_RST_IRQ = 2'h0;
  localparam logic DTP_RST_PSSEL = 1'b0;

  // ==========================================================
  // Operating modes
  typedef enum logic [2:0] {
    DTP_MODE_TIMER = 3'h0,
    DTP_MODE_DIVIDER = 3'h1,
    DTP_MODE_PWM8 = 3'h2,
    DTP_MODE_RSVD = 3'h3,
    DTP_MODE_TIMER16 = 3'h4,
    DTP_MODE_WARMUP = 3'h5,
    DTP_MODE_PWM16 = 3'h6,
    DTP_MODE_PULSE16 = 3'h7
  } dtp_mode_t;

  // Clock select codes; 7 is the external count pin
  localparam logic [2:0] DTP_CK_SLOWEST = 3'h0;
  localparam logic [2:0] DTP_CK_DIV7 = 3'h1;
  localparam logic [2:0] DTP_CK_DIV5 = 3'h2;
  localparam logic [2:0] DTP_CK_DIV3 = 3'h3;
  localparam logic [2:0] DTP_CK_FS = 3'h4;
  localparam logic [2:0] DTP_CK_DIV1 = 3'h5;
  localparam logic [2:0] DTP_CK_FULL = 3'h6;
  localparam logic [2:0] DTP_CK_PIN = 3'h7;

  // ==========================================================
  // Timing: low-frequency clock derived from the system clock
  localparam int DTP_SYS_CLK_HZ = 40000000;
  localparam int DTP_FS_HZ = 32768;
  localparam int DTP_FS_DIV_CYCLES = DTP_SYS_CLK_HZ / DTP_FS_HZ;
  localparam int DTP_PRESC_W = 11;
  localparam int DTP_FS_DIV_W = 11;
  localparam int DTP_FS_SUB_W = 3;

endpackage

// ---- src/dtp_prescaler.sv ----
// Prescaler: one-cycle enable pulses for every internal count rate
`timescale 1ns/10ps
module dtp_prescaler
  import dtp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic src_sel_i,
  output logic [7:0] tick_o
);

  logic [DTP_PRESC_W-1:0] pre_q, pre_d;
  logic [DTP_FS_DIV_W-1:0] fs_q, fs_d;
  logic [DTP_FS_SUB_W-1:0] fs8_q, fs8_d;
  logic [7:0] tick_q, tick_d;
  logic fs_tick, fs8_tick;

  // ==========================================================
  // Dividers
  always_comb
  begin
    pre_d = pre_q + 1'b1;
    fs_tick = (fs_q == DTP_FS_DIV_W'(DTP_FS_DIV_CYCLES - 1));
    fs_d = fs_tick ? '0 : fs_q + 1'b1;
    fs8_tick = fs_tick & (&fs8_q);
    fs8_d = fs_tick ? fs8_q + 1'b1 : fs8_q;
    tick_d = '0;
    // Slowest rate comes from the high or low clock chain
    tick_d[DTP_CK_SLOWEST] = src_sel_i ? fs8_tick : (&pre_q[10:0]);
    tick_d[DTP_CK_DIV7] = &pre_q[6:0];
    tick_d[DTP_CK_DIV5] = &pre_q[4:0];
    tick_d[DTP_CK_DIV3] = &pre_q[2:0];
    tick_d[DTP_CK_FS] = fs_tick;
    tick_d[DTP_CK_DIV1] = pre_q[0];
    tick_d[DTP_CK_FULL] = 1'b1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pre_q <= '0;
      fs_q <= '0;
      fs8_q <= '0;
      tick_q <= '0;
    end
    else
    begin
      pre_q <= pre_d;
      fs_q <= fs_d;
      fs8_q <= fs8_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule

// ---- src/dtp_channel.sv ----
// One 8-bit up-counter with its output flip-flop and inverted pin
`timescale 1ns/10ps
module dtp_channel
  import dtp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic inc_i,
  input wire logic clr_i,
  input wire logic toggle_i,
  input wire logic ff_wr_i,
  input wire logic ff_val_i,
  output logic [7:0] cnt_o,
  output logic ff_o,
  output logic pin_n_o
);

  logic [7:0] cnt_q, cnt_d;
  logic ff_q, ff_d;
  logic pin_n_q;

  always_comb
  begin
    cnt_d = cnt_q;
    ff_d = ff_q;
    if (!run_i)
      cnt_d = '0;
    else if (clr_i)
      cnt_d = '0;
    else if (inc_i)
      cnt_d = cnt_q + 1'b1;
    if (ff_wr_i)
      ff_d = ff_val_i;
    else if (toggle_i)
      ff_d = ~ff_q;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      ff_q <= 1'b0;
      pin_n_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      ff_q <= ff_d;
      pin_n_q <= ~ff_d;
    end
  end

  assign cnt_o = cnt_q;
  assign ff_o = ff_q;
  assign pin_n_o = pin_n_q;

endmodule

// ---- src/dtp_timer.sv ----
// Dual cascadable 8-bit timer/event counter with divider outputs and Avalon-MM registers
`timescale 1ns/10ps
module dtp_timer
  import dtp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [1:0] count_input_pin_i,
  output logic [1:0] divider_out_pin_o,
  output logic match_interrupt_o
);
  import dtp_pkg::*;

  // ==========================================================
  // Bus slave: one wait state on every access
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic acc, wr_en;

  // ==========================================================
  // Register state
  logic [7:0] counter_control_reg_q [2];
  logic [7:0] counter_control_reg_d [2];
  logic [7:0] compare_reg_q [2];
  logic [7:0] compare_reg_d [2];
  logic [1:0] irq_sts_q, irq_sts_d;
  logic [1:0] irq_mask_q, irq_mask_d;
  logic pssel_q, pssel_d;
  logic irq_q, irq_d;
  logic [1:0] ctrl_wr, ff_wr;

  // ==========================================================
  // Counting datapath
  logic [7:0] tick;
  logic [1:0] sync1_q, sync2_q, sync3_q;
  logic [1:0] pin_fall, src, run, inc, clr, toggle, start, ff_val, ff;
  logic [2:0] cksel [2];
  logic [2:0] mode [2];
  logic [7:0] cnt [2];
  logic [1:0] pin_n;
  logic [1:0] match8, evt;
  logic cascade, match16;
  logic [15:0] cnt16_next;

  assign acc = (avs_read_i | avs_write_i) & wait_q;
  assign wr_en = avs_write_i & ~wait_q;

  dtp_prescaler u_presc (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .src_sel_i(pssel_q),
    .tick_o(tick)
  );

  // ==========================================================
  // Per-channel field decode, pin edge detection and channel
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ch
      assign mode[g] = counter_control_reg_q[g][DTP_CTRL_MODE_LSB +: DTP_MODE_W];
      assign cksel[g] = counter_control_reg_q[g][DTP_CTRL_CKSEL_LSB +: 3];
      assign start[g] = counter_control_reg_q[g][DTP_CTRL_START_BIT];
      assign ff_val[g] = avs_writedata_i[DTP_CTRL_FF_BIT];
      assign ctrl_wr[g] = wr_en & avs_byteenable_i[0]
        & (avs_address_i == (g == 0 ? DTP_OFS_CTRL0 : DTP_OFS_CTRL1));
      // Flip-flop loads only on a write made while stopped, so a stopping write holds the pin
      assign ff_wr[g] = ctrl_wr[g] & ~start[g];
      // Third stage only feeds the edge detector; first stage is read by the second alone
      assign pin_fall[g] = sync3_q[g] & ~sync2_q[g];
      assign src[g] = (cksel[g] == DTP_CK_PIN) ? pin_fall[g] : tick[cksel[g]];
      assign match8[g] = inc[g] & ((cnt[g] + 8'h01) == compare_reg_q[g]);

      dtp_channel u_ch (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .run_i(run[g]),
        .inc_i(inc[g]),
        .clr_i(clr[g]),
        .toggle_i(toggle[g]),
        .ff_wr_i(ff_wr[g]),
        .ff_val_i(ff_val[g]),
        .cnt_o(cnt[g]),
        .ff_o(ff[g]),
        .pin_n_o(pin_n[g])
      );
    end
  endgenerate

  // ==========================================================
  // Run, increment, match and cascade control
  always_comb
  begin
    cascade = mode[1][DTP_MODE_CASCADE_BIT];
    // Upper start bit governs the whole 16-bit counter
    run[0] = cascade ? start[1] : start[0];
    run[1] = start[1];
    inc[0] = run[0] & src[0];
    inc[1] = cascade ? (inc[0] & (cnt[0] == 8'hFF)) : (run[1] & src[1]);
    cnt16_next = {cnt[1], cnt[0]} + 16'h0001;
    match16 = inc[0] & (cnt16_next == {compare_reg_q[1], compare_reg_q[0]});
    clr[0] = cascade ? match16 : match8[0];
    clr[1] = cascade ? match16 : match8[1];
    toggle[0] = match8[0] & ~cascade & (mode[0] == DTP_MODE_DIVIDER);
    toggle[1] = match8[1] & ~cascade & (mode[1] == DTP_MODE_DIVIDER);
    evt[0] = match8[0] & ~cascade;
    evt[1] = cascade ? match16 : match8[1];
  end

  // ==========================================================
  // Register writes, interrupt flags and read mux
  always_comb
  begin
    counter_control_reg_d = counter_control_reg_q;
    compare_reg_d = compare_reg_q;
    irq_mask_d = irq_mask_q;
    pssel_d = pssel_q;
    irq_sts_d = irq_sts_q;
    rdata_d = rdata_q;
    wait_d = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      if (ctrl_wr[i])
        counter_control_reg_d[i] = avs_writedata_i[7:0];
    end
    if (wr_en & avs_byteenable_i[0])
    begin
      unique case (avs_address_i)
        DTP_OFS_CMP0: compare_reg_d[0] = avs_writedata_i[7:0];
        DTP_OFS_CMP1: compare_reg_d[1] = avs_writedata_i[7:0];
        DTP_OFS_IRQ_STS: irq_sts_d = irq_sts_q & ~avs_writedata_i[1:0];
        DTP_OFS_IRQ_MASK: irq_mask_d = avs_writedata_i[1:0];
        DTP_OFS_MISC: pssel_d = avs_writedata_i[DTP_MISC_PSSEL_BIT];
        default: ;
      endcase
    end
    // A match in the clearing cycle still sets its flag
    irq_sts_d = irq_sts_d | evt;
    irq_d = |(irq_sts_d & irq_mask_d);
    if (acc)
    begin
      wait_d = 1'b0;
      rdata_d = 32'h0000_0000;
      unique case (avs_address_i)
        DTP_OFS_CTRL0: rdata_d[7:0] = {ff[0], counter_control_reg_q[0][6:0]};
        DTP_OFS_CTRL1: rdata_d[7:0] = {ff[1], counter_control_reg_q[1][6:0]};
        DTP_OFS_CMP0: rdata_d[7:0] = compare_reg_q[0];
        DTP_OFS_CMP1: rdata_d[7:0] = compare_reg_q[1];
        DTP_OFS_COUNT: rdata_d[15:0] = {cnt[1], cnt[0]};
        DTP_OFS_IRQ_STS: rdata_d[1:0] = irq_sts_q;
        DTP_OFS_IRQ_MASK: rdata_d[1:0] = irq_mask_q;
        DTP_OFS_MISC: rdata_d[DTP_MISC_PSSEL_BIT] = pssel_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      counter_control_reg_q[0] <= DTP_RST_CTRL;
      counter_control_reg_q[1] <= DTP_RST_CTRL;
      compare_reg_q[0] <= DTP_RST_CMP;
      compare_reg_q[1] <= DTP_RST_CMP;
      irq_sts_q <= DTP_RST_IRQ;
      irq_mask_q <= DTP_RST_IRQ;
      pssel_q <= DTP_RST_PSSEL;
      irq_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      sync1_q <= 2'h3;
      sync2_q <= 2'h3;
      sync3_q <= 2'h3;
    end
    else
    begin
      counter_control_reg_q <= counter_control_reg_d;
      compare_reg_q <= compare_reg_d;
      irq_sts_q <= irq_sts_d;
      irq_mask_q <= irq_mask_d;
      pssel_q <= pssel_d;
      irq_q <= irq_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      sync1_q <= count_input_pin_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign divider_out_pin_o = pin_n;
  assign match_interrupt_o = irq_q;

endmodule

// ---- sim/dtp_timer_props.sv ----
// Checker: bus handshake, pin and interrupt relations of the dual timer
`timescale 1ns/10ps
module dtp_timer_props
  import dtp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] divider_out_pin_o,
  input wire logic match_interrupt_o
);
  logic acc, wr_ok, ctl_wr;
  logic [1:0] st_q, st_d, msk_q, msk_d;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Shadow of start bits and mask, from accepted writes
  assign acc = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
  assign wr_ok = acc && avs_write_i && avs_byteenable_i[0];
  assign ctl_wr = wr_ok && (avs_address_i == DTP_OFS_CTRL0 || avs_address_i == DTP_OFS_CTRL1);
  always_comb
  begin
    st_d = st_q;
    msk_d = msk_q;
    if (ctl_wr)
      st_d[avs_address_i[2]] = avs_writedata_i[DTP_CTRL_START_BIT];
    if (wr_ok && avs_address_i == DTP_OFS_IRQ_MASK)
      msk_d = avs_writedata_i[1:0];
  end
  always_ff @(posedge sys_clk_i)
  begin
    st_q <= rst_i ? 2'h0 : st_d;
    msk_q <= rst_i ? 2'h0 : msk_d;
  end
  // ==========================================
  // Properties
  sequence req_s;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence ans_s;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  wait_once_a: assert property (req_s |=> ans_s)
    else $error("bus answer not one wait state");
  wait_idle_a: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest dropped without request");
  reset_pins_a: assert property ($fell(rst_i) |-> divider_out_pin_o == 2'h3 && !match_interrupt_o)
    else $error("pins or interrupt wrong after reset");
  pin_hold_a: assert property (st_q == 2'h0 && !ctl_wr |=> ctl_wr || $stable(divider_out_pin_o))
    else $error("divider pin moved while stopped");
  irq_mask_a: assert property (msk_q == 2'h0 |-> !match_interrupt_o)
    else $error("interrupt with all sources masked");
  ff_read_a: assert property (acc && avs_read_i && avs_address_i == DTP_OFS_CTRL1 |->
    avs_readdata_o[DTP_CTRL_FF_BIT] == !$past(divider_out_pin_o[1]))
    else $error("pin not inverse of flip-flop");
  rd_upper_a: assert property (acc && avs_read_i |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  rd_unmapped_a: assert property (acc && avs_read_i && avs_address_i[1:0] != 2'h0 |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
endmodule

// ---- sim/dtp_partner.sv ----
// Partner: external event source on the count pins
`timescale 1ns/10ps
module dtp_partner
(
  input wire logic sys_clk_i,
  output logic [1:0] pin_o
);
  initial pin_o = 2'h3;
  // Shortest legal pulse: two cycles low, two high
  task automatic pulse(input int ch);
    @(posedge sys_clk_i);
    pin_o[ch] <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    pin_o[ch] <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
  endtask
endmodule

// ---- sim/tb_dtp_timer.sv ----
// Testbench: register-level scenarios for the dual 8-bit timer
`timescale 1ns/10ps
module tb_dtp_timer;
  import dtp_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o, q;
  logic avs_waitrequest_o, match_interrupt_o;
  logic [1:0] count_input_pin_i, divider_out_pin_o;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 32'hC36A;
  int t0, t1, c_a, c_b;
  // Bench model: clock cycles per tick for selects 0 to 5, fast chain
  int rate_div[6] = '{2048, 128, 32, 8, DTP_FS_DIV_CYCLES, 2};
  int exp_q[$];
  always #12.5 sys_clk_i = ~sys_clk_i;
  dtp_timer dut_u (.sys_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .count_input_pin_i, .divider_out_pin_o,
    .match_interrupt_o);
  dtp_partner par_u (.sys_clk_i, .pin_o(count_input_pin_i));
  task conclude();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Run ceiling well above the longest scenario
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      num_errors++;
      conclude();
    end
  end
  // ==========================================
  // Bus and wait helpers
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Idle edge after release keeps strobes from being reassigned in one step
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge sys_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge sys_clk_i);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task rdc(input logic [4:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  // Extra edge lets the registered interrupt fall first
  task clr();
    bus(1'b1, DTP_OFS_IRQ_STS, 32'h3);
    @(posedge sys_clk_i);
  endtask
  task irq_wait(output int t);
    while (match_interrupt_o !== 1'b1) @(posedge sys_clk_i);
    t = cyc;
  endtask
  // Shared port latch sits outside the block; the pin is read as if it were set
  task pin_wait(input int ch, output int t);
    logic v;
    v = divider_out_pin_o[ch];
    while (divider_out_pin_o[ch] === v) @(posedge sys_clk_i);
    t = cyc;
  endtask
  // ==========================================
  // Scenarios
  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    chk("reset pins", 32'(divider_out_pin_o), 32'h3);
    rdc(DTP_OFS_CTRL1, 32'(DTP_RST_CTRL), "ctrl1");
    rdc(DTP_OFS_IRQ_MASK, 32'(DTP_RST_IRQ), "mask");
    rdc(5'h02, 32'h0, "unmapped");
    avs_byteenable_i <= 4'h0;
    bus(1'b1, DTP_OFS_CMP0, 32'h55);
    avs_byteenable_i <= 4'hF;
    rdc(DTP_OFS_CMP0, 32'(DTP_RST_CMP), "be0 write");
    c_a = 10 + ($random(seed) & 31);
    c_b = 16 + ($random(seed) & 15);
    bus(1'b1, DTP_OFS_CMP0, c_a);
    bus(1'b1, DTP_OFS_IRQ_MASK, 32'h1);
    bus(1'b1, DTP_OFS_CTRL0, 32'h68);
    irq_wait(t0);
    clr();
    irq_wait(t1);
    chk("timer period", t1 - t0, c_a);
    clr();
    bus(1'b1, DTP_OFS_CMP0, c_b);
    irq_wait(t0);
    chk("new compare", t0 - t1, c_b);
    bus(1'b1, DTP_OFS_IRQ_MASK, 32'h0);
    clr();
    repeat (c_b + 2) @(posedge sys_clk_i);
    chk("masked irq", 32'(match_interrupt_o), 32'h0);
    rdc(DTP_OFS_IRQ_STS, 32'h1, "timer sts");
    bus(1'b1, DTP_OFS_CTRL0, 32'h60);
    rdc(DTP_OFS_COUNT, 32'h0, "stop clears");
    clr();
    bus(1'b1, DTP_OFS_CMP0, 32'h4);
    bus(1'b1, DTP_OFS_CTRL0, 32'h78);
    repeat (3) par_u.pulse(0);
    repeat (4) @(posedge sys_clk_i);
    rdc(DTP_OFS_COUNT, 32'h3, "events");
    par_u.pulse(0);
    repeat (4) @(posedge sys_clk_i);
    rdc(DTP_OFS_COUNT, 32'h0, "event wrap");
    rdc(DTP_OFS_IRQ_STS, 32'h1, "event sts");
    bus(1'b1, DTP_OFS_CTRL0, 32'h60);
    clr();
    c_a = 12 + ($random(seed) & 15);
    bus(1'b1, DTP_OFS_CMP1, c_a);
    bus(1'b1, DTP_OFS_CTRL1, 32'h69);
    pin_wait(1, t0);
    pin_wait(1, t1);
    chk("half period", t1 - t0, c_a);
    // Two toggles from the loaded zero leave the flip-flop at zero
    chk("pin after two", 32'(divider_out_pin_o[1]), 32'h1);
    rdc(DTP_OFS_CTRL1, 32'h69, "ff state");
    rdc(DTP_OFS_IRQ_STS, 32'h2, "divider sts");
    bus(1'b1, DTP_OFS_CTRL1, 32'h61);
    repeat (2 * c_a) @(posedge sys_clk_i);
    chk("held pin", 32'(divider_out_pin_o[1]), 32'h1);
    bus(1'b1, DTP_OFS_CTRL1, 32'hE1);
    chk("ff load", 32'(divider_out_pin_o[1]), 32'h0);
    bus(1'b1, DTP_OFS_CTRL1, 32'h61);
    chk("ff clear", 32'(divider_out_pin_o[1]), 32'h1);
    clr();
    bus(1'b1, DTP_OFS_IRQ_MASK, 32'h2);
    bus(1'b1, DTP_OFS_CMP0, 32'h2C);
    bus(1'b1, DTP_OFS_CMP1, 32'h01);
    // Upper select left slowest: only the lower select may clock it
    bus(1'b1, DTP_OFS_CTRL1, 32'h0C);
    irq_wait(t0);
    clr();
    irq_wait(t1);
    chk("cascade period", t1 - t0, 300);
    rdc(DTP_OFS_IRQ_STS, 32'h2, "cascade sts");
    bus(1'b1, DTP_OFS_CTRL1, 32'h04);
    rdc(DTP_OFS_COUNT, 32'h0, "cascade stop");
    // ==========================================
    // Lower divider at internal selects 0 to 5; select kept when stopping
    bus(1'b1, DTP_OFS_CTRL1, 32'h00);
    bus(1'b1, DTP_OFS_CMP0, 32'h3);
    for (int s = 0; s < 6; s++)
    begin
      exp_q.push_back(3 * rate_div[s]);
      bus(1'b1, DTP_OFS_CTRL0, {25'h0, s[2:0], 4'h9});
      pin_wait(0, t0);
      pin_wait(0, t1);
      chk("rate half period", t1 - t0, exp_q.pop_front());
      bus(1'b1, DTP_OFS_CTRL0, {25'h0, s[2:0], 4'h1});
    end
    // Low-speed source: only the fs/8 select is used
    bus(1'b1, DTP_OFS_MISC, 32'h1);
    bus(1'b1, DTP_OFS_CMP0, 32'h1);
    bus(1'b1, DTP_OFS_CTRL0, 32'h09);
    exp_q.push_back(8 * DTP_FS_DIV_CYCLES);
    pin_wait(0, t0);
    pin_wait(0, t1);
    chk("slow half period", t1 - t0, exp_q.pop_front());
    bus(1'b1, DTP_OFS_CTRL0, 32'h01);
    conclude();
  end
endmodule
bind dtp_timer dtp_timer_props chk_u (.sys_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .divider_out_pin_o,
  .match_interrupt_o);
